/* File: design/dhgt_params.svh */
// Offsets, field positions and counts of the dual half timer
`ifndef DHGT_PARAMS_SVH
`define DHGT_PARAMS_SVH
`define DHGT_OFF_CFG 12'h000
`define DHGT_OFF_CTRL 12'h004
`define DHGT_OFF_HMODE 12'h008
`define DHGT_OFF_ADCEV 12'h00C
`define DHGT_OFF_LOADA 12'h010
`define DHGT_OFF_LOADB 12'h014
`define DHGT_OFF_MATCHA 12'h018
`define DHGT_OFF_MATCHB 12'h01C
`define DHGT_OFF_VALA 12'h020
`define DHGT_OFF_VALB 12'h024
`define DHGT_OFF_CAPA 12'h028
`define DHGT_OFF_CAPB 12'h02C
`define DHGT_OFF_RIS 12'h030
`define DHGT_OFF_IMR 12'h034
`define DHGT_OFF_MIS 12'h038
`define DHGT_CTRL_EN 0
`define DHGT_CTRL_CLK 2
`define DHGT_CTRL_INV 3
`define DHGT_CTRL_STALL 5
`define DHGT_CTRL_TRIG 7
`define DHGT_CTRL_EDGE 9
`define DHGT_HM_B 8
`define DHGT_EV_TMO 0
`define DHGT_EV_CMATCH 1
`define DHGT_EV_CEV 2
`define DHGT_EV_RTC 3
`define DHGT_EV_MMATCH 4
`define DHGT_EV_B 8
`define DHGT_EV_VALID 16'h171F
`define DHGT_RTC_DIV_MAX 15'h7FFF
`endif

/* File: design/dhgt_pkg.sv */
// Types shared by the dual half timer files
`default_nettype none
package dhgt_pkg;
  typedef enum logic [2:0] {
    DHGT_FULL_OS_DN, DHGT_FULL_OS_UP, DHGT_FULL_PER_DN,
    DHGT_FULL_PER_UP, DHGT_FULL_RTC, DHGT_SPLIT
  } dhgt_cfg_t;
  typedef enum logic [2:0] {
    DHGT_ONESHOT, DHGT_PERIODIC, DHGT_HALF_EDGE_COUNT_CAPTURE,
    DHGT_HALF_EDGE_TIME_CAPTURE, DHGT_PWM_ONESHOT, DHGT_PWM
  } dhgt_kind_t;
  typedef struct packed {
    logic up;
    dhgt_kind_t kind;
  } dhgt_hmode_t;
  typedef enum logic [3:0] {
    DHGT_ACT_NONE, DHGT_ACT_TIMEOUT_IRQ_SUPPRESS, DHGT_ACT_TOGGLE,
    DHGT_ACT_SET, DHGT_ACT_CLR, DHGT_ACT_SET_TOG, DHGT_ACT_CLR_TOG,
    DHGT_ACT_SET_CLR, DHGT_ACT_CLR_SET
  } dhgt_act_t;
  typedef enum logic [1:0] {DHGT_EDGE_POS, DHGT_EDGE_NEG, DHGT_EDGE_BOTH} dhgt_edge_t;
  typedef struct packed {
    logic tmo;
    logic stop;
    logic [31:0] cnt;
  } dhgt_step_t;
  typedef struct packed {
    dhgt_cfg_t cfg;
    logic [1:0] en;
    logic [1:0] en_q;
    logic clk_sel_precise_osc;
    logic [1:0] inv;
    logic [1:0] stall;
    logic [1:0] trig_en;
    dhgt_edge_t [1:0] edge_sel;
    dhgt_hmode_t [1:0] mode;
    dhgt_act_t [1:0] act;
    logic [15:0] adc_en;
    logic [1:0][15:0] load;
    logic [1:0][15:0] match;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] cap;
    logic [15:0] ris;
    logic [15:0] imr;
    logic [1:0] ccp_out;
    logic [1:0] ccp_oe;
    logic irq;
    logic adc_trig;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dhgt_state_t;
endpackage : dhgt_pkg
`default_nettype wire

/* File: design/dhgt_sync_edge.sv */
// Pin synchroniser with selectable edge detection
`timescale 1ns/10ps
`default_nettype none
module dhgt_sync_edge import dhgt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  input wire dhgt_edge_t edge_sel,
  output logic level,
  output logic pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } dhgt_sync_t;
  dhgt_sync_t s;
  dhgt_sync_t next_s;
  logic rise;
  logic fall;

  // Two stages, then one for edge history
  always_comb begin
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.s2;
  assign rise = s.s2 & ~s.s3;
  assign fall = ~s.s2 & s.s3;

  always_comb begin
    case (edge_sel)
      DHGT_EDGE_POS: pulse = rise;
      DHGT_EDGE_NEG: pulse = fall;
      default: pulse = rise | fall;
    endcase
  end

  property p_neg_edge;
    @(posedge pclk) disable iff (!presetn)
    (edge_sel == DHGT_EDGE_NEG) && pulse |-> !level && $past(level);
  endproperty
  a_neg_edge: assert property (p_neg_edge) else $error("falling pick fired off edge");
endmodule : dhgt_sync_edge
`default_nettype wire

/* File: design/dhgt_rtc_div.sv */
// Divider from 32768 clock edges to a one second tick
`timescale 1ns/10ps
`default_nettype none
`include "dhgt_params.svh"
module dhgt_rtc_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic edge_in,
  output logic sec_tick
);
  typedef struct packed {
    logic [14:0] div;
  } dhgt_div_t;
  dhgt_div_t s;
  dhgt_div_t next_s;

  always_comb begin
    next_s = s;
    if (!run) begin
      next_s.div = 15'h0000;
    end else if (edge_in) begin
      next_s.div = s.div + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sec_tick = run & edge_in & (s.div == `DHGT_RTC_DIV_MAX);
endmodule : dhgt_rtc_div
`default_nettype wire

/* File: design/dhgt_top.sv */
// Dual half general timer with APB registers
`timescale 1ns/10ps
`default_nettype none
`include "dhgt_params.svh"
module dhgt_top import dhgt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ccp_in,
  output logic [1:0] ccp_out,
  output logic [1:0] ccp_oe,
  input wire logic precise_osc_clk,
  input wire logic rtc_clk_32k,
  input wire logic debug_halted,
  output logic irq,
  output logic adc_trig
);
  dhgt_state_t s;
  dhgt_state_t n;
  logic [3:0] edge_ev;
  logic [3:0] raw_in;
  logic sec_tick;
  logic cnt_tick;
  logic [1:0] live;
  logic [1:0] run;
  logic acc;
  logic wr;
  logic locked;
  logic [31:0] load32;
  logic [31:0] match32;
  logic [31:0] cnt32;
  logic [31:0] rd;
  logic [15:0] clr;
  logic [15:0] ev_all;
  logic [15:0] supp;
  logic [15:0] trig_mask;
  logic [1:0] tmo_h;
  logic [1:0] start_h;
  logic [1:0] is_tmr;
  logic [1:0] pwm_h;
  logic up_full;
  dhgt_step_t st;

  // Next count, timeout and stop for a timer step
  function automatic dhgt_step_t step_count(input logic [31:0] cnt,
      input logic [31:0] load, input logic up, input logic periodic);
    dhgt_step_t r;
    r = '0;
    r.cnt = cnt;
    if (up ? (cnt >= load) : (cnt == 32'h0000_0000)) begin
      r.tmo = 1'b1;
      r.stop = ~periodic;
      if (periodic) begin
        r.cnt = up ? 32'h0000_0000 : load;
      end
    end else begin
      r.cnt = up ? cnt + 32'h0000_0001 : cnt - 32'h0000_0001;
    end
    return r;
  endfunction : step_count

  // Mapped register addresses
  function automatic logic addr_ok(input logic [11:0] a);
    case (a)
      `DHGT_OFF_CFG, `DHGT_OFF_CTRL, `DHGT_OFF_HMODE, `DHGT_OFF_ADCEV,
      `DHGT_OFF_LOADA, `DHGT_OFF_LOADB, `DHGT_OFF_MATCHA, `DHGT_OFF_MATCHB,
      `DHGT_OFF_VALA, `DHGT_OFF_VALB, `DHGT_OFF_CAPA, `DHGT_OFF_CAPB,
      `DHGT_OFF_RIS, `DHGT_OFF_IMR, `DHGT_OFF_MIS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  // Pins pass two flops before use
  assign raw_in = {rtc_clk_32k, precise_osc_clk, ccp_in};
  for (genvar g = 0; g < 4; g++) begin : g_sync
    dhgt_sync_edge u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(raw_in[g]),
      .edge_sel((g < 2) ? s.edge_sel[g % 2] : DHGT_EDGE_POS),
      .level(),
      .pulse(edge_ev[g])
    );
  end

  dhgt_rtc_div u_rtc (
    .pclk(pclk),
    .presetn(presetn),
    .run(s.en[0] && (s.cfg == DHGT_FULL_RTC)),
    .edge_in(edge_ev[3]),
    .sec_tick(sec_tick)
  );

  // one shared tick for both halves
  assign cnt_tick = s.clk_sel_precise_osc ? edge_ev[2] : 1'b1;
  assign live = s.en & ~(s.stall & {2{debug_halted}});
  assign run = live & {2{cnt_tick}};
  assign acc = psel & penable & ~s.pready;
  assign wr = psel & penable & s.pready & pwrite & ~s.pslverr;
  assign locked = |s.en;
  assign load32 = {s.load[1], s.load[0]};
  assign match32 = {s.match[1], s.match[0]};
  assign trig_mask = {{8{s.trig_en[1]}}, {8{s.trig_en[0]}}};
  assign up_full = (s.cfg == DHGT_FULL_OS_UP) || (s.cfg == DHGT_FULL_PER_UP);

  always_comb begin
    n = s;
    rd = 32'h0000_0000;
    clr = 16'h0000;
    ev_all = 16'h0000;
    supp = 16'h0000;
    tmo_h = 2'b00;
    start_h = s.en & ~s.en_q;
    is_tmr = 2'b00;
    pwm_h = 2'b00;
    st = '0;
    cnt32 = {s.cnt[1], s.cnt[0]};
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.en_q = s.en;
    n.ccp_oe = 2'b00;
    // Read data selection
    case (paddr)
      `DHGT_OFF_CFG: rd[2:0] = s.cfg;
      `DHGT_OFF_CTRL: begin
        rd[`DHGT_CTRL_EN +: 2] = s.en;
        rd[`DHGT_CTRL_CLK] = s.clk_sel_precise_osc;
        rd[`DHGT_CTRL_INV +: 2] = s.inv;
        rd[`DHGT_CTRL_STALL +: 2] = s.stall;
        rd[`DHGT_CTRL_TRIG +: 2] = s.trig_en;
        rd[`DHGT_CTRL_EDGE +: 4] = {s.edge_sel[1], s.edge_sel[0]};
      end
      `DHGT_OFF_HMODE: rd[15:0] = {s.act[1], s.mode[1], s.act[0], s.mode[0]};
      `DHGT_OFF_ADCEV: rd[15:0] = s.adc_en;
      `DHGT_OFF_LOADA: rd[15:0] = s.load[0];
      `DHGT_OFF_LOADB: rd[15:0] = s.load[1];
      `DHGT_OFF_MATCHA: rd[15:0] = s.match[0];
      `DHGT_OFF_MATCHB: rd[15:0] = s.match[1];
      `DHGT_OFF_VALA: rd[15:0] = s.cnt[0];
      `DHGT_OFF_VALB: rd[15:0] = s.cnt[1];
      `DHGT_OFF_CAPA: rd[15:0] = s.cap[0];
      `DHGT_OFF_CAPB: rd[15:0] = s.cap[1];
      `DHGT_OFF_RIS: rd[15:0] = s.ris;
      `DHGT_OFF_IMR: rd[15:0] = s.imr;
      `DHGT_OFF_MIS: rd[15:0] = s.ris & s.imr;
      default: rd = 32'h0000_0000;
    endcase
    if (acc) begin
      n.pready = 1'b1;
      n.prdata = rd;
      n.pslverr = ~addr_ok(paddr) | (pwrite & locked &
          ((paddr == `DHGT_OFF_CFG) || (paddr == `DHGT_OFF_HMODE)));
    end
    // Register writes at the completing edge
    if (wr) begin
      case (paddr)
        `DHGT_OFF_CFG: begin
          n.cfg = dhgt_cfg_t'(pwdata[2:0]);
          n.en = 2'b00;
        end
        `DHGT_OFF_CTRL: begin
          n.en = pwdata[`DHGT_CTRL_EN +: 2];
          n.clk_sel_precise_osc = pwdata[`DHGT_CTRL_CLK];
          n.inv = pwdata[`DHGT_CTRL_INV +: 2];
          n.stall = pwdata[`DHGT_CTRL_STALL +: 2];
          n.trig_en = pwdata[`DHGT_CTRL_TRIG +: 2];
          n.edge_sel[0] = dhgt_edge_t'(pwdata[`DHGT_CTRL_EDGE +: 2]);
          n.edge_sel[1] = dhgt_edge_t'(pwdata[(`DHGT_CTRL_EDGE + 2) +: 2]);
        end
        // separate mode and action per half
        `DHGT_OFF_HMODE: begin
          n.mode[0] = dhgt_hmode_t'(pwdata[3:0]);
          n.act[0] = dhgt_act_t'(pwdata[7:4]);
          n.mode[1] = dhgt_hmode_t'(pwdata[`DHGT_HM_B +: 4]);
          n.act[1] = dhgt_act_t'(pwdata[(`DHGT_HM_B + 4) +: 4]);
        end
        `DHGT_OFF_ADCEV: n.adc_en = pwdata[15:0] & `DHGT_EV_VALID;
        `DHGT_OFF_LOADA: n.load[0] = pwdata[15:0];
        `DHGT_OFF_LOADB: n.load[1] = pwdata[15:0];
        `DHGT_OFF_MATCHA: n.match[0] = pwdata[15:0];
        `DHGT_OFF_MATCHB: n.match[1] = pwdata[15:0];
        `DHGT_OFF_RIS: clr = pwdata[15:0] & `DHGT_EV_VALID;
        `DHGT_OFF_IMR: n.imr = pwdata[15:0] & `DHGT_EV_VALID;
        default: ;
      endcase
    end
    // split pair, each half its own mode
    if (s.cfg == DHGT_SPLIT) begin
      for (int i = 0; i < 2; i++) begin
        case (s.mode[i].kind)
          DHGT_HALF_EDGE_COUNT_CAPTURE: begin
            if (start_h[i]) begin
              n.cnt[i] = s.mode[i].up ? 16'h0000 : s.load[i];
            end else if (live[i] && edge_ev[i]) begin
              ev_all[i * `DHGT_EV_B + `DHGT_EV_CEV] = 1'b1;
              n.cnt[i] = s.mode[i].up ? s.cnt[i] + 16'h0001 : s.cnt[i] - 16'h0001;
              if (n.cnt[i] == s.match[i]) begin
                ev_all[i * `DHGT_EV_B + `DHGT_EV_CMATCH] = 1'b1;
                n.en[i] = 1'b0;
              end
            end
          end
          default: begin
            pwm_h[i] = (s.mode[i].kind == DHGT_PWM) || (s.mode[i].kind == DHGT_PWM_ONESHOT);
            is_tmr[i] = (s.mode[i].kind == DHGT_ONESHOT) || (s.mode[i].kind == DHGT_PERIODIC);
            if (start_h[i]) begin
              n.cnt[i] = (s.mode[i].up && !pwm_h[i]) ? 16'h0000 : s.load[i];
            end else if (run[i]) begin
              // stop or reload at the end
              st = step_count({16'h0000, s.cnt[i]}, {16'h0000, s.load[i]},
                  s.mode[i].up && !pwm_h[i],
                  (s.mode[i].kind != DHGT_ONESHOT) && (s.mode[i].kind != DHGT_PWM_ONESHOT));
              n.cnt[i] = st.cnt[15:0];
              tmo_h[i] = st.tmo;
              if (st.stop) begin
                n.en[i] = 1'b0;
              end
              if (is_tmr[i] && (s.cnt[i] == s.match[i])) begin
                ev_all[i * `DHGT_EV_B + `DHGT_EV_MMATCH] = 1'b1;
              end
            end
            if ((s.mode[i].kind == DHGT_HALF_EDGE_TIME_CAPTURE) && live[i] && edge_ev[i]) begin
              n.cap[i] = s.cnt[i];
              ev_all[i * `DHGT_EV_B + `DHGT_EV_CEV] = 1'b1;
            end
            if (pwm_h[i]) begin
              n.ccp_oe[i] = 1'b1;
              n.ccp_out[i] = (n.cnt[i] > s.match[i]) ^ s.inv[i];
            end
          end
        endcase
      end
    end else begin
      // full width modes on half A controls
      is_tmr[0] = (s.cfg != DHGT_FULL_RTC);
      if (start_h[0]) begin
        cnt32 = up_full ? 32'h0000_0000 : load32;
      end else if (s.cfg == DHGT_FULL_RTC) begin
        if (live[0] && sec_tick) begin
          cnt32 = cnt32 + 32'h0000_0001;
          if (cnt32 == match32) begin
            ev_all[`DHGT_EV_RTC] = 1'b1;
          end
        end
      end else if (run[0]) begin
        st = step_count(cnt32, load32, up_full,
            (s.cfg == DHGT_FULL_PER_DN) || (s.cfg == DHGT_FULL_PER_UP));
        if (cnt32 == match32) begin
          ev_all[`DHGT_EV_MMATCH] = 1'b1;
        end
        cnt32 = st.cnt;
        tmo_h[0] = st.tmo;
        if (st.stop) begin
          n.en[0] = 1'b0;
        end
      end
      n.cnt[0] = cnt32[15:0];
      n.cnt[1] = cnt32[31:16];
    end
    // Timeout events and pin actions per half
    for (int i = 0; i < 2; i++) begin
      if (tmo_h[i]) begin
        ev_all[i * `DHGT_EV_B + `DHGT_EV_TMO] = 1'b1;
      end
      if (is_tmr[i]) begin
        n.ccp_oe[i] = (s.act[i] != DHGT_ACT_NONE) && (s.act[i] != DHGT_ACT_TIMEOUT_IRQ_SUPPRESS);
        if (tmo_h[i] && (s.act[i] == DHGT_ACT_TIMEOUT_IRQ_SUPPRESS)) begin
          supp[i * `DHGT_EV_B + `DHGT_EV_TMO] = 1'b1;
        end
        if (start_h[i]) begin
          case (s.act[i])
            DHGT_ACT_SET_TOG, DHGT_ACT_SET_CLR: n.ccp_out[i] = 1'b1;
            DHGT_ACT_CLR_TOG, DHGT_ACT_CLR_SET: n.ccp_out[i] = 1'b0;
            default: ;
          endcase
        end else if (tmo_h[i]) begin
          case (s.act[i])
            DHGT_ACT_TOGGLE, DHGT_ACT_SET_TOG, DHGT_ACT_CLR_TOG: n.ccp_out[i] = ~s.ccp_out[i];
            DHGT_ACT_SET, DHGT_ACT_CLR_SET: n.ccp_out[i] = 1'b1;
            DHGT_ACT_CLR, DHGT_ACT_SET_CLR: n.ccp_out[i] = 1'b0;
            default: ;
          endcase
        end
      end
    end
    // Status sets win over same-cycle clears
    n.ris = (s.ris & ~clr) | (ev_all & ~supp);
    n.irq = |(n.ris & n.imr);
    // enabled event in an enabled half
    n.adc_trig = |(ev_all & s.adc_en & trig_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign ccp_out = s.ccp_out;
  assign ccp_oe = s.ccp_oe;
  assign irq = s.irq;
  assign adc_trig = s.adc_trig;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_cfg_locked;
    acc && pwrite && (paddr == `DHGT_OFF_CFG) && locked |=> s.pslverr ##1 $stable(s.cfg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("cfg changed while on");
  property p_cfg_off;
    wr && (paddr == `DHGT_OFF_CFG) |=> (s.en == 2'b00) [*2];
  endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("enabled after configure");
  property p_one_stop;
    (s.cfg == DHGT_SPLIT) && (s.mode[0].kind == DHGT_ONESHOT) && tmo_h[0] && !wr |=> !s.en[0];
  endproperty
  a_one_stop: assert property (p_one_stop) else $error("one-shot kept running");
  property p_reload;
    (s.cfg == DHGT_FULL_PER_DN) && tmo_h[0] && !wr
      |=> ({s.cnt[1], s.cnt[0]} == $past({s.load[1], s.load[0]})) && s.en[0];
  endproperty
  a_reload: assert property (p_reload) else $error("periodic did not reload");
  property p_stall;
    s.stall[0] && debug_halted && s.en[0] && s.en_q[0]
      |=> s.cnt[0] == $past(s.cnt[0]);
  endproperty
  a_stall: assert property (p_stall) else $error("counted in debug stall");
  property p_osc_tick;
    (s.cfg != DHGT_SPLIT) && (s.cfg != DHGT_FULL_RTC) && s.clk_sel_precise_osc
      && !edge_ev[2] && s.en_q[0] |=> $stable({s.cnt[1], s.cnt[0]});
  endproperty
  a_osc_tick: assert property (p_osc_tick) else $error("counted without osc tick");
  property p_rtc_sec;
    (s.cfg == DHGT_FULL_RTC) && !sec_tick && s.en_q[0] |=> $stable({s.cnt[1], s.cnt[0]});
  endproperty
  a_rtc_sec: assert property (p_rtc_sec) else $error("rtc moved off second");
  property p_pwm_inv;
    (s.cfg == DHGT_SPLIT) && (s.mode[0].kind == DHGT_PWM) && $past(s.mode[0].kind == DHGT_PWM)
      && $stable(s.match[0]) && $stable(s.inv[0]) && $past(s.cfg == DHGT_SPLIT)
      |-> s.ccp_out[0] == ((s.cnt[0] > s.match[0]) ^ s.inv[0]);
  endproperty
  a_pwm_inv: assert property (p_pwm_inv) else $error("pwm level wrong");
  property p_act_set;
    is_tmr[0] && tmo_h[0] && (s.act[0] == DHGT_ACT_SET) |=> s.ccp_out[0] && s.ccp_oe[0];
  endproperty
  a_act_set: assert property (p_act_set) else $error("pin not set at timeout");
  property p_act_force;
    is_tmr[1] && start_h[1] && (s.act[1] == DHGT_ACT_CLR_SET) |=> !s.ccp_out[1];
  endproperty
  a_act_force: assert property (p_act_force) else $error("pin not forced low");
  property p_suppress;
    is_tmr[0] && tmo_h[0] && (s.act[0] == DHGT_ACT_TIMEOUT_IRQ_SUPPRESS) && !s.ris[0]
      |=> !s.ris[`DHGT_EV_TMO];
  endproperty
  a_suppress: assert property (p_suppress) else $error("suppressed timeout flagged");
  property p_adc_half;
    s.adc_trig |-> $past(|(ev_all & s.adc_en & trig_mask));
  endproperty
  a_adc_half: assert property (p_adc_half) else $error("adc trigger without cause");
  property p_adc_gate;
    s.adc_trig |-> $past(s.trig_en != 2'b00);
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("adc trigger from gated half");

  c_pwm: cover property ((s.cfg == DHGT_SPLIT) && pwm_h[1] && tmo_h[1]);
  c_rtc: cover property (ev_all[`DHGT_EV_RTC]);
  c_cap: cover property (ev_all[`DHGT_EV_CMATCH]);
  c_adc: cover property (s.adc_trig && s.irq);
endmodule : dhgt_top
`default_nettype wire

/* File: testbench/dhgt_pin_model.sv */
// Far-side model of the two capture/compare pins
`timescale 1ns/10ps
`default_nettype none
module dhgt_pin_model (
  input wire logic [1:0] ccp_out,
  input wire logic [1:0] ccp_oe,
  input wire logic [1:0] ext_lvl,
  output logic [1:0] ccp_in
);
  // Pin follows the timer while driven, else the outside source
  assign ccp_in = (ccp_oe & ccp_out) | (~ccp_oe & ext_lvl);
endmodule : dhgt_pin_model
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the dual half timer
`timescale 1ns/10ps
`default_nettype none
`include "dhgt_params.svh"
module tb import dhgt_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] ext_lvl = 2'h0;
  logic osc = 1'b0;
  logic rtc = 1'b0;
  logic dbg = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ccp_in;
  logic [1:0] ccp_out;
  logic [1:0] ccp_oe;
  logic irq;
  logic adc_trig;
  logic [31:0] rd;
  logic [31:0] v0;
  logic err;
  logic p0;
  int n_mismatch = 0;
  int compares = 0;
  int c;

  dhgt_top u_dhgt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe),
    .precise_osc_clk(osc), .rtc_clk_32k(rtc), .debug_halted(dbg), .irq(irq),
    .adc_trig(adc_trig));
  dhgt_pin_model u_dhgt_pin_model (.ccp_out(ccp_out), .ccp_oe(ccp_oe), .ext_lvl(ext_lvl),
    .ccp_in(ccp_in));

  // Clock of 50 ns
  initial begin
    forever #25 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic end_sim;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // APB transfer, entered just after a rising edge
  task automatic apb(input int wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr[0];
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Wait for the next ADC trigger pulse
  task automatic wait_trig;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (adc_trig !== 1'b1 && c < 50);
  endtask : wait_trig

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `DHGT_OFF_CFG, 0);
    chk(rd, 0);
    apb(0, `DHGT_OFF_CTRL, 0);
    chk(rd, 0);
    apb(0, 12'h040, 0);
    chk({rd[30:0], err}, 1);
    // Periodic down, load 3, toggle on timeout, ADC on timeout
    apb(1, `DHGT_OFF_CFG, 2);
    apb(1, `DHGT_OFF_LOADA, 3);
    apb(1, `DHGT_OFF_HMODE, 32'h0000_0020);
    apb(1, `DHGT_OFF_IMR, 1);
    apb(1, `DHGT_OFF_ADCEV, 1);
    apb(1, `DHGT_OFF_CTRL, 32'h0000_0081);
    wait_trig();
    p0 = ccp_out[0];
    wait_trig();
    chk(c, 4);
    chk(ccp_out[0] ^ p0, 1);
    chk({ccp_oe[0], irq}, 2'h3);
    apb(1, `DHGT_OFF_CFG, 3);
    chk(err, 1);
    // ADC gate closed by half trigger enable
    apb(1, `DHGT_OFF_CTRL, 1);
    wait_trig();
    chk(c, 50);
    apb(1, `DHGT_OFF_CTRL, 0);
    apb(1, `DHGT_OFF_RIS, 32'h0000_FFFF);
    apb(0, `DHGT_OFF_RIS, 0);
    chk({rd[30:0], irq}, 0);
    // Stall in debug, then stopped oscillator as clock source
    apb(1, `DHGT_OFF_LOADA, 32'h0000_0100);
    dbg <= 1'b1;
    apb(1, `DHGT_OFF_CTRL, 32'h0000_0021);
    apb(0, `DHGT_OFF_VALA, 0);
    v0 = rd;
    apb(0, `DHGT_OFF_VALA, 0);
    chk(rd, v0);
    apb(1, `DHGT_OFF_CTRL, 1);
    apb(0, `DHGT_OFF_VALA, 0);
    chk(rd !== v0, 1);
    apb(1, `DHGT_OFF_CTRL, 0);
    apb(1, `DHGT_OFF_CTRL, 5);
    apb(0, `DHGT_OFF_VALA, 0);
    v0 = rd;
    apb(0, `DHGT_OFF_VALA, 0);
    chk(rd, v0);
    // Four oscillator rising edges, four counts
    repeat (4) begin
      osc <= 1'b1;
      repeat (2) @(posedge pclk);
      osc <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    apb(0, `DHGT_OFF_VALA, 0);
    chk(rd, 32'h0000_00FC);
    // Split, half A edge time on falling edges only
    apb(1, `DHGT_OFF_CTRL, 0);
    apb(1, `DHGT_OFF_CFG, 5);
    apb(1, `DHGT_OFF_HMODE, 3);
    apb(1, `DHGT_OFF_CTRL, 32'h0000_0201);
    ext_lvl <= 2'h1;
    repeat (4) @(posedge pclk);
    apb(0, `DHGT_OFF_RIS, 0);
    chk(rd & 4, 0);
    ext_lvl <= 2'h0;
    repeat (4) @(posedge pclk);
    apb(0, `DHGT_OFF_RIS, 0);
    chk(rd & 4, 4);
    // PWM level with and without inversion, match at 0xFFFF so no count exceeds it
    apb(1, `DHGT_OFF_CTRL, 0);
    apb(1, `DHGT_OFF_HMODE, 5);
    apb(1, `DHGT_OFF_MATCHA, 32'h0000_FFFF);
    apb(1, `DHGT_OFF_CTRL, 8);
    repeat (2) @(posedge pclk);
    chk({ccp_oe[0], ccp_out[0]}, 3);
    apb(1, `DHGT_OFF_CTRL, 0);
    repeat (2) @(posedge pclk);
    chk({ccp_oe[0], ccp_out[0]}, 2);
    // One-shot A sets its pin at timeout, B forced high at start
    apb(1, `DHGT_OFF_HMODE, 32'h0000_7030);
    apb(1, `DHGT_OFF_LOADA, 2);
    apb(1, `DHGT_OFF_LOADB, 32'h0000_0100);
    apb(1, `DHGT_OFF_CTRL, 3);
    repeat (10) @(posedge pclk);
    chk({ccp_oe, ccp_out}, 4'hF);
    apb(0, `DHGT_OFF_CTRL, 0);
    chk(rd[1:0], 2);
    // A timeout hidden from status, B forced low at start
    apb(1, `DHGT_OFF_CTRL, 0);
    apb(1, `DHGT_OFF_RIS, 32'h0000_FFFF);
    apb(1, `DHGT_OFF_HMODE, 32'h0000_8010);
    apb(1, `DHGT_OFF_CTRL, 3);
    repeat (10) @(posedge pclk);
    chk({ccp_oe, ccp_out[1]}, 4);
    apb(0, `DHGT_OFF_RIS, 0);
    chk(rd & 1, 0);
    apb(0, `DHGT_OFF_CTRL, 0);
    chk(rd[1:0], 2);
    // RTC holds its start value between second ticks
    apb(1, `DHGT_OFF_CTRL, 0);
    apb(1, `DHGT_OFF_CFG, 4);
    apb(1, `DHGT_OFF_LOADA, 5);
    apb(1, `DHGT_OFF_CTRL, 1);
    repeat (4) begin
      rtc <= 1'b1;
      repeat (2) @(posedge pclk);
      rtc <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    apb(0, `DHGT_OFF_VALA, 0);
    chk(rd, 5);
    end_sim();
  end
endmodule : tb
`default_nettype wire
